// File: core/option_cfg_pkg.sv
// constants and types for the option byte configuration decoder
package option_cfg_pkg;

  // ****************************************
  // byte indices and factory content
  // ****************************************
  localparam logic       IDX_BYTE0    = 1'h0;  // option_config_byte0
  localparam logic       IDX_BYTE1    = 1'h1;  // option_config_byte1
  localparam logic [7:0] ERASED_BYTE  = 8'hFF; // blank flash content
  localparam logic [7:0] FACTORY_BYTE0 = 8'hE7; // shipped byte 0
  localparam logic [7:0] FACTORY_BYTE1 = 8'hEF; // shipped byte 1, internal rc

  // ****************************************
  // field positions, byte 0
  // ****************************************
  localparam int POS_WATCHDOG_HALT_RESET_SEL  = 7; // watchdog_halt_reset_sel
  localparam int POS_WDG_TYPE  = 6; // watchdog_type_sel
  localparam int POS_SUPPLY_HI = 4; // supply_detect_level msb
  localparam int POS_SUPPLY_LO = 3; // supply_detect_level lsb
  localparam int POS_PKG_LOW   = 1; // package_sel_low
  localparam int POS_PROTECT_N = 0; // readout_protect_n

  // ****************************************
  // field positions, byte 1
  // ****************************************
  localparam int POS_PKG_HIGH  = 7; // package_sel_high
  localparam int POS_RST_DELAY = 6; // reset_delay_sel
  localparam int POS_SRC_HI    = 5; // clock_source_kind msb
  localparam int POS_SRC_LO    = 4; // clock_source_kind lsb
  localparam int POS_BAND_HI   = 3; // osc_freq_band msb
  localparam int POS_BAND_LO   = 1; // osc_freq_band lsb
  localparam int POS_DOUBLER_N = 0; // doubler_disable

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] SUPPLY_OFF     = 2'h3; // both detectors off
  localparam logic [1:0] SUPPLY_LOWEST  = 2'h2; // lowest threshold
  localparam logic [1:0] SUPPLY_MEDIUM  = 2'h1; // medium threshold
  localparam logic [1:0] SUPPLY_HIGHEST = 2'h0; // highest threshold
  localparam logic [1:0] SRC_RESONATOR  = 2'h0; // resonator oscillator
  localparam logic [1:0] SRC_RESERVED   = 2'h1; // not a valid source
  localparam logic [1:0] SRC_INTERNAL   = 2'h2; // internal rc
  localparam logic [1:0] SRC_EXTERNAL   = 2'h3; // external source
  localparam logic [2:0] BAND_1_2MHZ    = 3'h0; // band_1_2mhz
  localparam logic [2:0] BAND_2_4MHZ    = 3'h1; // band_2_4mhz
  localparam logic [2:0] BAND_4_8MHZ    = 3'h2; // band_4_8mhz
  localparam logic [2:0] BAND_8_16MHZ   = 3'h3; // band_8_16mhz
  localparam logic [1:0] PKG_80_LEAD    = 2'h3; // 80-lead package code

  // ****************************************
  // reset delay counts in cpu cycles
  // ****************************************
  localparam int          DELAY_LONG_CYC  = 4096; // reset_delay_sel = 0
  localparam int          DELAY_SHORT_CYC = 256;  // reset_delay_sel = 1
  localparam int          DELAY_W         = 13;   // counter width
  localparam logic [12:0] DELAY_LONG_LOAD  = 13'(DELAY_LONG_CYC - 1);
  localparam logic [12:0] DELAY_SHORT_LOAD = 13'(DELAY_SHORT_CYC - 1);

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {LD_SAMPLE, LD_DELAY, LD_RUN} load_state_t;
  typedef enum logic [1:0] {ER_IDLE, ER_USER, ER_OPTION} erase_state_t;

endpackage

// File: core/option_store.sv
// two-byte nonvolatile option storage with registered read data
`timescale 1ns/1ns
`default_nettype none

module option_store (
  // clock and power-on reset
  input  wire logic       clk_in,
  input  wire logic       por_in,
  // write and erase
  input  wire logic       wr_in,
  input  wire logic       sel_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       erase_in,
  // read
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // raw contents
  output logic      [7:0] byte0_out,
  output logic      [7:0] byte1_out
);

  logic [7:0] next_byte0; // next byte 0
  logic [7:0] next_byte1; // next byte 1
  logic [7:0] next_rdata; // next read data

  // write, erase and read selection
  always_comb begin
    next_byte0 = byte0_out;
    next_byte1 = byte1_out;
    next_rdata = rdata_out;
    if (erase_in) begin
      next_byte0 = option_cfg_pkg::ERASED_BYTE;
      next_byte1 = option_cfg_pkg::ERASED_BYTE;
    end else if (wr_in) begin
      if (sel_in == option_cfg_pkg::IDX_BYTE0) begin
        next_byte0 = wdata_in;
      end else begin
        next_byte1 = wdata_in;
      end
    end
    if (rd_in) begin
      next_rdata = (sel_in == option_cfg_pkg::IDX_BYTE0) ? byte0_out : byte1_out;
    end
  end

  // only power-on restores factory content
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      byte0_out <= option_cfg_pkg::FACTORY_BYTE0;
      byte1_out <= option_cfg_pkg::FACTORY_BYTE1;
      rdata_out <= 8'h00;
    end else begin
      byte0_out <= next_byte0;
      byte1_out <= next_byte1;
      rdata_out <= next_rdata;
    end
  end

  blank_after_a: assert property (@(posedge clk_in) disable iff (por_in) erase_in
    |=> byte0_out == option_cfg_pkg::ERASED_BYTE && byte1_out == option_cfg_pkg::ERASED_BYTE)
    else $error("erase did not blank option bytes");

endmodule

`default_nettype wire

// File: core/option_byte_config_decoder.sv
// option byte configuration decoder: storage access, sampling and decode
//
// Operation
// - halt entry resets when watchdog active, bit set
// - watchdog type: hardware always on, software optional
// - supply detect code: off, lowest, medium, highest
// - protection bit low blocks reads and flash writes
// - protected option erase wipes user memory first
// - package bits; 11 means 80-lead package
// - unbonded pads leave reset as pulled-up inputs
// - reset delay 4096 or 256 cycles, halt exit
// - clock source: resonator, reserved, internal, external
// - oscillator band selects 1-2 to 8-16 MHz
// - doubler bit low enables times-two clock
// - option bytes reachable only in programming mode
// - blank option storage reads as FFh
// - factory content selects internal rc clock
`timescale 1ns/1ns
`default_nettype none

module option_byte_config_decoder #(
  parameter int          PADS          = 64,   // pads across all ports
  parameter logic [63:0] UNBONDED_MASK = '0    // pads without pins, 80-lead
) (
  // clock and resets
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            por_in,
  // programming port
  input  wire logic            prog_mode_in,
  input  wire logic            prog_sel_in,
  input  wire logic            prog_wr_in,
  input  wire logic            prog_rd_in,
  input  wire logic      [7:0] prog_wdata_in,
  input  wire logic            prog_erase_in,
  output logic           [7:0] prog_rdata_out,
  output logic                 prog_busy_out,
  // user memory erase handshake
  output logic                 user_erase_req_out,
  input  wire logic            user_erase_done_in,
  // system events
  input  wire logic            halt_enter_in,
  input  wire logic            halt_exit_in,
  input  wire logic            sw_wdg_enable_in,
  output logic                 cpu_reset_hold_out,
  output logic                 watchdog_halt_reset_out,
  output logic                 watchdog_enable_out,
  // protection
  output logic                 flash_read_block_out,
  output logic                 flash_write_block_out,
  // decoded configuration
  output logic           [1:0] supply_detect_level_out,
  output logic                 supply_detect_on_out,
  output logic           [1:0] package_code_out,
  output logic                 package_80_lead_out,
  output logic           [1:0] clock_source_kind_out,
  output logic           [2:0] osc_freq_band_out,
  output logic                 doubler_enable_out,
  output logic      [PADS-1:0] pad_pullup_out
);
  default clocking @(posedge clk_in); endclocking // clock of every check below
  default disable iff (rst_in);                   // checks rest while device reset

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] store0;      // stored byte 0
  logic [7:0] store1;      // stored byte 1
  logic       store_wr;    // qualified write
  logic       store_erase; // option erase strobe
  logic       store_rd;    // qualified read

  option_store option_store_inst (
    .clk_in    (clk_in),
    .por_in    (por_in),
    .wr_in     (store_wr),
    .sel_in    (prog_sel_in),
    .wdata_in  (prog_wdata_in),
    .erase_in  (store_erase),
    .rd_in     (store_rd),
    .rdata_out (prog_rdata_out),
    .byte0_out (store0),
    .byte1_out (store1)
  );

  // ****************************************
  // erase sequencing
  // ****************************************
  option_cfg_pkg::erase_state_t er_state;      // erase state
  option_cfg_pkg::erase_state_t next_er_state; // next erase state

  // erase request handling
  always_comb begin
    next_er_state = er_state;
    case (er_state)
      option_cfg_pkg::ER_IDLE: begin
        // protected erase goes through user memory
        if (prog_mode_in && prog_erase_in) begin
          next_er_state = store0[option_cfg_pkg::POS_PROTECT_N] ?
                          option_cfg_pkg::ER_OPTION : option_cfg_pkg::ER_USER;
        end
      end
      option_cfg_pkg::ER_USER: begin
        if (user_erase_done_in) begin
          next_er_state = option_cfg_pkg::ER_OPTION;
        end
      end
      option_cfg_pkg::ER_OPTION: begin
        next_er_state = option_cfg_pkg::ER_IDLE;
      end
      default: begin
        next_er_state = option_cfg_pkg::ER_IDLE;
      end
    endcase
  end

  // erase state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      er_state <= option_cfg_pkg::ER_IDLE;
    end else begin
      er_state <= next_er_state;
    end
  end

  // writes only in programming mode and idle; reads in programming mode
  assign store_wr           = prog_mode_in && prog_wr_in && (er_state == option_cfg_pkg::ER_IDLE)
                              && !prog_erase_in;
  assign store_rd           = prog_mode_in && prog_rd_in;
  assign store_erase        = (er_state == option_cfg_pkg::ER_OPTION);
  assign user_erase_req_out = (er_state == option_cfg_pkg::ER_USER);
  assign prog_busy_out      = (er_state != option_cfg_pkg::ER_IDLE);

  // ****************************************
  // sampling and reset delay
  // ****************************************
  option_cfg_pkg::load_state_t ld_state;      // loader state
  option_cfg_pkg::load_state_t next_ld_state; // next loader state
  logic [7:0]  cfg0;       // held byte 0
  logic [7:0]  cfg1;       // held byte 1
  logic [7:0]  next_cfg0;  // next held byte 0
  logic [7:0]  next_cfg1;  // next held byte 1
  logic [12:0] delay;      // cycles left in reset phase
  logic [12:0] next_delay; // next count
  logic [12:0] hold_run;      // cycles held so far, for checks
  logic [12:0] next_hold_run; // next held count

  // delay load value from the given delay bit
  function automatic logic [12:0] delay_load(input logic sel);
    delay_load = sel ? option_cfg_pkg::DELAY_SHORT_LOAD : option_cfg_pkg::DELAY_LONG_LOAD;
  endfunction

  // sample, count, run
  always_comb begin
    next_ld_state = ld_state;
    next_cfg0     = cfg0;
    next_cfg1     = cfg1;
    next_delay    = delay;
    next_hold_run = cpu_reset_hold_out ? hold_run + 13'h0001 : 13'h0000; // run length of the hold
    case (ld_state)
      option_cfg_pkg::LD_SAMPLE: begin
        next_cfg0     = store0;
        next_cfg1     = store1;
        // delay length from the fresh sample
        next_delay    = delay_load(store1[option_cfg_pkg::POS_RST_DELAY]);
        next_ld_state = option_cfg_pkg::LD_DELAY;
      end
      option_cfg_pkg::LD_DELAY: begin
        if (delay == 13'h0000) begin
          next_ld_state = option_cfg_pkg::LD_RUN;
        end else begin
          next_delay = delay - 13'h0001;
        end
      end
      option_cfg_pkg::LD_RUN: begin
        if (halt_exit_in) begin
          next_delay    = delay_load(cfg1[option_cfg_pkg::POS_RST_DELAY]);
          next_ld_state = option_cfg_pkg::LD_DELAY;
        end
      end
      default: begin
        next_ld_state = option_cfg_pkg::LD_SAMPLE;
      end
    endcase
  end

  // loader registers; held bytes reset to factory content
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ld_state <= option_cfg_pkg::LD_SAMPLE;
      cfg0     <= option_cfg_pkg::FACTORY_BYTE0;
      cfg1     <= option_cfg_pkg::FACTORY_BYTE1;
      delay    <= option_cfg_pkg::DELAY_LONG_LOAD;
      hold_run <= 13'h0000;
    end else begin
      ld_state <= next_ld_state;
      cfg0     <= next_cfg0;
      cfg1     <= next_cfg1;
      delay    <= next_delay;
      hold_run <= next_hold_run;
    end
  end

  assign cpu_reset_hold_out = (ld_state != option_cfg_pkg::LD_RUN);

  // ****************************************
  // watchdog
  // ****************************************
  logic next_halt_reset; // next halt reset pulse

  // hardware type forces the watchdog on
  assign watchdog_enable_out = !cfg0[option_cfg_pkg::POS_WDG_TYPE] || sw_wdg_enable_in;

  // reset on halt entry with active watchdog
  always_comb begin
    next_halt_reset = halt_enter_in && watchdog_enable_out && cfg0[option_cfg_pkg::POS_WATCHDOG_HALT_RESET_SEL]
                      && (ld_state == option_cfg_pkg::LD_RUN);
  end

  // halt reset pulse register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_halt_reset_out <= 1'b0;
    end else begin
      watchdog_halt_reset_out <= next_halt_reset;
    end
  end

  // ****************************************
  // decoded fields
  // ****************************************
  // protection blocks extraction and writes
  assign flash_read_block_out    = !cfg0[option_cfg_pkg::POS_PROTECT_N];
  assign flash_write_block_out   = !cfg0[option_cfg_pkg::POS_PROTECT_N];
  assign supply_detect_level_out = cfg0[option_cfg_pkg::POS_SUPPLY_HI:option_cfg_pkg::POS_SUPPLY_LO];
  assign supply_detect_on_out    = (supply_detect_level_out != option_cfg_pkg::SUPPLY_OFF);
  assign package_code_out        = {cfg1[option_cfg_pkg::POS_PKG_HIGH], cfg0[option_cfg_pkg::POS_PKG_LOW]};
  assign package_80_lead_out     = (package_code_out == option_cfg_pkg::PKG_80_LEAD);
  assign clock_source_kind_out   = cfg1[option_cfg_pkg::POS_SRC_HI:option_cfg_pkg::POS_SRC_LO];
  assign osc_freq_band_out       = cfg1[option_cfg_pkg::POS_BAND_HI:option_cfg_pkg::POS_BAND_LO];
  assign doubler_enable_out      = !cfg1[option_cfg_pkg::POS_DOUBLER_N];

  // unbonded pads held as pulled-up inputs
  generate
    for (genvar gi = 0; gi < PADS; gi++) begin : g_pad
      assign pad_pullup_out[gi] = UNBONDED_MASK[gi];
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  // held bytes never move after sampling
  cfg_held_a: assert property ($past(ld_state) != option_cfg_pkg::LD_SAMPLE
    |-> $stable(cfg0) && $stable(cfg1)) else $error("held option bytes changed after sampling");
  // halt reset one cycle after cause
  halt_reset_a: assert property (halt_enter_in && watchdog_enable_out && cfg0[7]
    && ld_state == option_cfg_pkg::LD_RUN |=> watchdog_halt_reset_out) else $error("missing halt reset");
  // no halt reset when bit clear
  halt_quiet_a: assert property (!cfg0[7] && !$past(rst_in) && $stable(cfg0)
    |-> !watchdog_halt_reset_out) else $error("halt reset with halt option clear");
  wdg_type_a: assert property (!cfg0[6] |-> watchdog_enable_out)
    else $error("hardware watchdog disabled");
  // short-delay halt exit holds exactly 256 cycles
  short_delay_a: assert property (ld_state == option_cfg_pkg::LD_RUN && halt_exit_in && cfg1[6]
    |=> ##256 !cpu_reset_hold_out && hold_run == 13'h0100) else $error("short reset delay wrong length");
  // long delay unbroken after 300 cycles
  long_delay_a: assert property (ld_state == option_cfg_pkg::LD_RUN && halt_exit_in && !cfg1[6]
    |=> ##300 cpu_reset_hold_out && hold_run == 13'h012C) else $error("long reset delay ended early");
  // protected erase asks for user erase first
  user_first_a: assert property (er_state == option_cfg_pkg::ER_IDLE && prog_mode_in && prog_erase_in
    && !store0[0] |=> user_erase_req_out && !store_erase) else $error("protected erase skipped user memory");
  prog_only_a: assert property (disable iff (rst_in || por_in) !prog_mode_in && !prog_busy_out
    |=> $stable(store0) && $stable(store1)) else $error("option bytes changed outside programming mode");
  protect_a: assert property (flash_write_block_out == !cfg0[0]
    && flash_read_block_out == flash_write_block_out) else $error("protection outputs disagree with option");
  cover_halt_reset_c: cover property (watchdog_halt_reset_out);
  cover_user_erase_c: cover property (user_erase_req_out ##1 store_erase);
  cover_halt_exit_c:  cover property (ld_state == option_cfg_pkg::LD_RUN && halt_exit_in);
endmodule

`default_nettype wire

// File: sim/user_memory_model.sv
// user memory model answering the erase request
`timescale 1ns/1ns
`default_nettype none

module user_memory_model #(
  parameter int LAG = 5  // cycles until erase completes
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // erase handshake
  input  wire logic req_in,
  output logic      done_out,
  output logic      seen_out
);
  int cnt;  // cycles since request rose

  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      done_out <= 1'h0;
      seen_out <= 1'h0;
    end else if (req_in) begin
      seen_out <= 1'h1;
      cnt <= cnt + 1;
      done_out <= (cnt >= LAG);
    end else begin
      cnt <= 0;
      done_out <= 1'h0;
    end
  end
endmodule

`default_nettype wire

// File: sim/option_byte_config_decoder_test.sv
// testbench for the option byte configuration decoder
`timescale 1ns/1ns
`default_nettype none

module option_byte_config_decoder_test;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [63:0] MASK = 64'hFF00_0000_0000_00F0; // unbonded pads
  logic        clk_in, rst_in, por_in, mode, sel, wr, rd, erase;
  logic        h_en, h_ex, sw_wdg, done, busy, req, hold, hrst, wdg_on;
  logic        rd_blk, wr_blk, sup_on, pkg80, dbl, seen;
  logic [7:0]  wdata, rdata;
  logic [1:0]  sup, pkg, src;
  logic [2:0]  band;
  logic [63:0] pads;
  int          n_mismatch, tests_run, n;

  option_byte_config_decoder #(.PADS(64), .UNBONDED_MASK(MASK)) option_byte_config_decoder_inst (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .prog_mode_in(mode),
    .prog_sel_in(sel), .prog_wr_in(wr), .prog_rd_in(rd), .prog_wdata_in(wdata),
    .prog_erase_in(erase), .prog_rdata_out(rdata), .prog_busy_out(busy),
    .user_erase_req_out(req), .user_erase_done_in(done), .halt_enter_in(h_en),
    .halt_exit_in(h_ex), .sw_wdg_enable_in(sw_wdg), .cpu_reset_hold_out(hold),
    .watchdog_halt_reset_out(hrst), .watchdog_enable_out(wdg_on),
    .flash_read_block_out(rd_blk), .flash_write_block_out(wr_blk),
    .supply_detect_level_out(sup), .supply_detect_on_out(sup_on),
    .package_code_out(pkg), .package_80_lead_out(pkg80), .clock_source_kind_out(src),
    .osc_freq_band_out(band), .doubler_enable_out(dbl), .pad_pullup_out(pads));

  user_memory_model #(.LAG(5)) user_memory_model_inst (
    .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .done_out(done), .seen_out(seen));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one programming port access
  task automatic acc(input logic m, input logic r, input logic w, input logic s, input logic [7:0] d);
    mode = m;
    rd = r;
    wr = w;
    sel = s;
    wdata = d;
    @(negedge clk_in);
    rd = 1'h0;
    wr = 1'h0;
    @(negedge clk_in);
  endtask

  task automatic prog(input logic [7:0] b0, input logic [7:0] b1);
    acc(1'h1, 1'h0, 1'h1, 1'h0, b0);
    acc(1'h1, 1'h0, 1'h1, 1'h1, b1);
  endtask

  // cycles until cpu hold drops
  task automatic wait_low(output int k);
    k = 0;
    do begin
      @(negedge clk_in);
      h_ex = 1'h0;
      k++;
    end while (hold === 1'h1 && k < 5000);
  endtask

  task automatic dev_reset(output int k);
    rst_in = 1'h1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'h0;
    wait_low(k);
  endtask

  // halt entry, count reset pulses
  task automatic halt_pulses(output int k);
    h_en = 1'h1;
    k = 0;
    repeat (4) begin
      @(negedge clk_in);
      h_en = 1'h0;
      k += int'(hrst === 1'h1);
    end
  endtask

  task automatic erase_run(input logic exp_seen);
    mode = 1'h1;
    erase = 1'h1;
    @(negedge clk_in);
    erase = 1'h0;
    chk("busy", busy, 1'h1);
    for (int i = 0; i < 100 && busy !== 1'h0; i++) @(negedge clk_in);
    chk("busy_end", busy, 1'h0);
    chk("erase_req", seen, exp_seen);
    acc(1'h1, 1'h1, 1'h0, 1'h0, 8'h00);
    chk("blank0", rdata, option_cfg_pkg::ERASED_BYTE);
    acc(1'h1, 1'h1, 1'h0, 1'h1, 8'h00);
    chk("blank1", rdata, option_cfg_pkg::ERASED_BYTE);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_factory;
    dev_reset(n);
    chk("hold256", n, option_cfg_pkg::DELAY_SHORT_CYC + 1);
    chk("src", src, option_cfg_pkg::SRC_INTERNAL);
    chk("pkg", pkg, option_cfg_pkg::PKG_80_LEAD);
    chk("pkg80", pkg80, 1'h1);
    chk("pads", pads, MASK);
    chk("rblk", rd_blk, 1'h0);
    chk("wblk", wr_blk, 1'h0);
    chk("dbl", dbl, 1'h0);
    chk("watchdog_type_sel", wdg_on, 1'h0);
    acc(1'h1, 1'h1, 1'h0, 1'h0, 8'h00);
    chk("rd0", rdata, option_cfg_pkg::FACTORY_BYTE0);
    acc(1'h1, 1'h1, 1'h0, 1'h1, 8'h00);
    acc(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
    chk("rd_off", rdata, option_cfg_pkg::FACTORY_BYTE1);
    acc(1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
    acc(1'h1, 1'h1, 1'h0, 1'h0, 8'h00);
    chk("wr_off", rdata, option_cfg_pkg::FACTORY_BYTE0);
  endtask

  task automatic t_codes;
    logic [1:0] c;
    logic [1:0] prev;
    prev = option_cfg_pkg::SRC_INTERNAL;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      prog({3'h7, c, 3'h7}, {2'h3, c, 1'h0, c, 1'h1});
      chk("held", src, prev);
      dev_reset(n);
      chk("supply", sup, c);
      chk("sup_on", sup_on, c != 2'h3);
      chk("source", src, c);
      chk("band", band, {1'h0, c});
      prev = c;
    end
  endtask

  task automatic t_wdg;
    prog(8'hA7, 8'hEF);
    dev_reset(n);
    chk("wdg_hw", wdg_on, 1'h1);
    halt_pulses(n);
    chk("halt_rst", n, 1);
    h_ex = 1'h1;
    wait_low(n);
    chk("halt_exit", n, option_cfg_pkg::DELAY_SHORT_CYC + 1);
    prog(8'h7F, 8'hEF);
    dev_reset(n);
    sw_wdg = 1'h1;
    @(negedge clk_in);
    chk("wdg_en", wdg_on, 1'h1);
    halt_pulses(n);
    chk("halt_off", n, 0);
    sw_wdg = 1'h0;
    erase_run(1'h0);
  endtask

  task automatic t_prot;
    prog(8'hFE, 8'h82);
    dev_reset(n);
    chk("hold4096", n, option_cfg_pkg::DELAY_LONG_CYC + 1);
    chk("rblk", rd_blk, 1'h1);
    chk("wblk", wr_blk, 1'h1);
    chk("dbl_on", dbl, 1'h1);
    chk("band24", band, option_cfg_pkg::BAND_2_4MHZ);
    chk("reson", src, option_cfg_pkg::SRC_RESONATOR);
    erase_run(1'h1);
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    // run needs about 6500 cycles; allow 25000
    #200000;
    n_mismatch++;
    close_out();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    {rst_in, por_in} = 2'h3;
    {mode, sel, wr, rd, erase, h_en, h_ex, sw_wdg} = 8'h00;
    wdata = 8'h00;
    @(negedge clk_in);
    por_in = 1'h0;
    t_factory();
    t_codes();
    t_wdg();
    t_prot();
    close_out();
  end
endmodule

`default_nettype wire
